// ==== common/ddc_pkg.sv ====
// Behaviour
// - Two controllers, seven channels each, fourteen total.
// - Each channel serves its assigned peripheral requests.
// - Each controller has its own arbiter.
// - Hardware request lines or software trigger selectable.
// - Four programmable channel priority levels per controller.
// - Equal priority: lower channel number wins.
// - Independent source/destination widths, pad or truncate.
// - Circular mode restarts after count completes.
// - Half, complete, error flags ORed into interrupt.
// - All four peripheral/memory transfer directions supported.
// - Either side may address any bus target.
// - Item count programmable up to 65536.
package ddc_pkg;

	localparam int DDC_NUM_CTRL    = 2;
	localparam int DDC_CH_PER_CTRL = 7;
	localparam int DDC_NUM_CH      = DDC_NUM_CTRL * DDC_CH_PER_CTRL;
	localparam int DDC_PRI_W       = 2;
	localparam int DDC_ADDR_W      = 9;
	localparam int DDC_NDT_W       = 16;
	localparam int DDC_CNT_W       = 17;

	// Register port address split: channel in the upper bits, word in the lower
	localparam int DDC_REG_LSB = 2;
	localparam int DDC_CH_LSB  = 5;

	localparam logic [2:0] DDC_REG_CTRL   = 3'h0;
	localparam logic [2:0] DDC_REG_COUNT  = 3'h1;
	localparam logic [2:0] DDC_REG_SRC    = 3'h2;
	localparam logic [2:0] DDC_REG_DST    = 3'h3;
	localparam logic [2:0] DDC_REG_STATUS = 3'h4;
	localparam logic [2:0] DDC_REG_REMAIN = 3'h5;

	// Channel control fields
	localparam int DDC_CTRL_W         = 11;
	localparam int DDC_CTRL_EN        = 0;
	localparam int DDC_CTRL_CIRC      = 1;
	localparam int DDC_CTRL_SWTRIG    = 2;
	localparam int DDC_CTRL_PRI_LSB   = 3;
	localparam int DDC_CTRL_SSIZE_LSB = 5;
	localparam int DDC_CTRL_DSIZE_LSB = 7;
	localparam int DDC_CTRL_SINC      = 9;
	localparam int DDC_CTRL_DINC      = 10;
	localparam logic [DDC_CTRL_W-1:0] DDC_CTRL_RESET = 11'h000;

	// Status flags
	localparam int DDC_FLAG_W  = 3;
	localparam int DDC_FLAG_HT = 0;
	localparam int DDC_FLAG_TC = 1;
	localparam int DDC_FLAG_TE = 2;

	localparam logic [1:0] DDC_SIZE_BYTE = 2'h0;
	localparam logic [1:0] DDC_SIZE_HALF = 2'h1;

	localparam logic [DDC_CNT_W-1:0] DDC_FULL_COUNT = 17'h10000;
	localparam logic [DDC_CNT_W-1:0] DDC_CNT_ONE    = 17'h00001;

	typedef enum logic [1:0] {
		ENG_IDLE,
		ENG_READ,
		ENG_WRITE
	} ddc_eng_state_type;

endpackage : ddc_pkg

// ==== hdl/ddc_top.sv ====
`timescale 1ns/1ns
module ddc_top
	import ddc_pkg::*;
(
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	// Register port
	input  wire logic [DDC_ADDR_W-1:0]   reg_addr,
	input  wire logic [31:0]             reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [31:0]             reg_rdata,
	// Peripheral request handshake and per-channel interrupt
	input  wire logic [DDC_NUM_CH-1:0]   per_req,
	output logic      [DDC_NUM_CH-1:0]   per_ack,
	output logic      [DDC_NUM_CH-1:0]   chan_irq,
	// System bus master, one per controller
	output logic      [DDC_NUM_CTRL-1:0] mem_req,
	output logic      [DDC_NUM_CTRL-1:0] mem_we,
	output logic      [31:0]             mem_addr  [DDC_NUM_CTRL],
	output logic      [1:0]              mem_size  [DDC_NUM_CTRL],
	output logic      [31:0]             mem_wdata [DDC_NUM_CTRL],
	input  wire logic [DDC_NUM_CTRL-1:0] mem_ack,
	input  wire logic [DDC_NUM_CTRL-1:0] mem_err,
	input  wire logic [31:0]             mem_rdata [DDC_NUM_CTRL]
);

	function automatic logic [31:0] size_step(input logic [1:0] sz);
		if (sz == DDC_SIZE_BYTE)
			return 32'h1;
		else if (sz == DDC_SIZE_HALF)
			return 32'h2;
		else
			return 32'h4;
	endfunction : size_step

	// Low lanes that an element of this width carries; the lanes above read as zero
	function automatic logic [31:0] size_mask(input logic [1:0] sz);
		if (sz == DDC_SIZE_BYTE)
			return 32'h000000ff;
		else if (sz == DDC_SIZE_HALF)
			return 32'h0000ffff;
		else
			return 32'hffffffff;
	endfunction : size_mask

	// A programmed count of zero means the full 65536 items
	function automatic logic [DDC_CNT_W-1:0] total_items(input logic [DDC_NDT_W-1:0] n);
		return (n == '0) ? DDC_FULL_COUNT : {1'b0, n};
	endfunction : total_items

	// Highest level first, lowest index first within a level
	function automatic logic [3:0] pick(input logic [DDC_CH_PER_CTRL-1:0] elig,
		input logic [DDC_CH_PER_CTRL*DDC_PRI_W-1:0] pri);
		logic [3:0] res;
		res = 4'h0;
		for (int lvl = 3; lvl >= 0; lvl--)
		begin
			for (int i = 0; i < DDC_CH_PER_CTRL; i++)
			begin
				if (!res[3] && elig[i] && pri[i*DDC_PRI_W +: DDC_PRI_W] == 2'(lvl))
					res = {1'b1, 3'(i)};
			end
		end
		return res;
	endfunction : pick

	logic [DDC_CTRL_W-1:0]        cfg_q     [DDC_NUM_CH];
	logic [DDC_NDT_W-1:0]         ndt_q     [DDC_NUM_CH];
	logic [31:0]                  src_q     [DDC_NUM_CH];
	logic [31:0]                  dst_q     [DDC_NUM_CH];
	logic [31:0]                  cur_src_q [DDC_NUM_CH];
	logic [31:0]                  cur_dst_q [DDC_NUM_CH];
	logic [DDC_CNT_W-1:0]         rem_q     [DDC_NUM_CH];
	logic [DDC_FLAG_W-1:0]        flags_q   [DDC_NUM_CH];
	logic [DDC_PRI_W-1:0]         chan_pri  [DDC_NUM_CH];
	logic [DDC_NUM_CH-1:0]        elig;
	logic [DDC_NUM_CH-1:0]        trig_ok;
	logic [DDC_NUM_CH-1:0]        wr_sel;
	logic [DDC_NUM_CH-1:0]        item_done;
	logic [DDC_NUM_CH-1:0]        item_err;
	logic [3:0]                   pick_res  [DDC_NUM_CTRL];
	ddc_eng_state_type            st_q      [DDC_NUM_CTRL];
	logic [3:0]                   act_q     [DDC_NUM_CTRL];
	logic [3:0]                   reg_ch;
	logic [2:0]                   reg_idx;
	logic                         reg_hit;

	assign reg_ch  = reg_addr[DDC_CH_LSB +: 4];
	assign reg_idx = reg_addr[DDC_REG_LSB +: 3];
	assign reg_hit = reg_ch < 4'(DDC_NUM_CH);

	// Request eligibility per channel
	always_comb
	begin
		for (int c = 0; c < DDC_NUM_CH; c++)
		begin
			chan_pri[c] = cfg_q[c][DDC_CTRL_PRI_LSB +: DDC_PRI_W];
			wr_sel[c]   = reg_wr && reg_ch == 4'(c);
			// An acked request is masked for one cycle while the peripheral drops it
			trig_ok[c]  = cfg_q[c][DDC_CTRL_SWTRIG] || (per_req[c] && !per_ack[c]);
			elig[c]     = cfg_q[c][DDC_CTRL_EN] && rem_q[c] != '0 && trig_ok[c];
		end
	end

	// One arbiter per controller over its own seven channels
	always_comb
	begin
		logic [DDC_CH_PER_CTRL*DDC_PRI_W-1:0] pv;
		pv = '0;
		for (int e = 0; e < DDC_NUM_CTRL; e++)
		begin
			for (int i = 0; i < DDC_CH_PER_CTRL; i++)
				pv[i*DDC_PRI_W +: DDC_PRI_W] = chan_pri[e*DDC_CH_PER_CTRL + i];
			pick_res[e] = pick(elig[e*DDC_CH_PER_CTRL +: DDC_CH_PER_CTRL], pv);
		end
	end

	// Engine completions seen by the channel registers
	always_comb
	begin
		item_done = '0;
		item_err  = '0;
		for (int e = 0; e < DDC_NUM_CTRL; e++)
		begin
			if (st_q[e] == ENG_WRITE && mem_ack[e] && !mem_err[e])
				item_done[act_q[e]] = 1'b1;
			if (st_q[e] != ENG_IDLE && mem_ack[e] && mem_err[e])
				item_err[act_q[e]] = 1'b1;
		end
	end

	// Transfer engines: one item is a read of the source then a write of the destination
	always_ff @(posedge clk_sys)
	begin
		for (int e = 0; e < DDC_NUM_CTRL; e++)
		begin
			if (rst)
			begin
				st_q[e]      <= ENG_IDLE;
				act_q[e]     <= 4'h0;
				mem_req[e]   <= 1'b0;
				mem_we[e]    <= 1'b0;
				mem_addr[e]  <= 32'h0;
				mem_size[e]  <= 2'h0;
				mem_wdata[e] <= 32'h0;
			end
			else
			begin
				unique case (st_q[e])
					ENG_IDLE:
					begin
						if (pick_res[e][3])
						begin
							act_q[e]    <= 4'(e * DDC_CH_PER_CTRL) + {1'b0, pick_res[e][2:0]};
							st_q[e]     <= ENG_READ;
							mem_req[e]  <= 1'b1;
							mem_we[e]   <= 1'b0;
							mem_addr[e] <= cur_src_q[4'(e * DDC_CH_PER_CTRL) + {1'b0, pick_res[e][2:0]}];
							mem_size[e] <= cfg_q[4'(e * DDC_CH_PER_CTRL) + {1'b0, pick_res[e][2:0]}][DDC_CTRL_SSIZE_LSB +: 2];
						end
					end
					ENG_READ:
					begin
						if (mem_ack[e] && mem_err[e])
						begin
							st_q[e]    <= ENG_IDLE;
							mem_req[e] <= 1'b0;
						end
						else if (mem_ack[e])
						begin
							st_q[e]      <= ENG_WRITE;
							mem_we[e]    <= 1'b1;
							mem_addr[e]  <= cur_dst_q[act_q[e]];
							mem_size[e]  <= cfg_q[act_q[e]][DDC_CTRL_DSIZE_LSB +: 2];
							// Narrow source is zero padded; narrow destination takes the low bits
							mem_wdata[e] <= mem_rdata[e] & size_mask(mem_size[e]) &
								size_mask(cfg_q[act_q[e]][DDC_CTRL_DSIZE_LSB +: 2]);
						end
					end
					ENG_WRITE:
					begin
						if (mem_ack[e])
						begin
							st_q[e]    <= ENG_IDLE;
							mem_req[e] <= 1'b0;
							mem_we[e]  <= 1'b0;
						end
					end
				endcase
			end
		end
	end

	// Channel configuration, progress and flags; engine updates win over a same-cycle write
	always_ff @(posedge clk_sys)
	begin
		for (int c = 0; c < DDC_NUM_CH; c++)
		begin
			if (rst)
			begin
				cfg_q[c]     <= DDC_CTRL_RESET;
				ndt_q[c]     <= '0;
				src_q[c]     <= 32'h0;
				dst_q[c]     <= 32'h0;
				cur_src_q[c] <= 32'h0;
				cur_dst_q[c] <= 32'h0;
				rem_q[c]     <= '0;
				flags_q[c]   <= '0;
			end
			else
			begin
				if (wr_sel[c] && reg_idx == DDC_REG_CTRL)
				begin
					cfg_q[c] <= reg_wdata[DDC_CTRL_W-1:0];
					if (reg_wdata[DDC_CTRL_EN] && !cfg_q[c][DDC_CTRL_EN])
					begin
						cur_src_q[c] <= src_q[c];
						cur_dst_q[c] <= dst_q[c];
						rem_q[c]     <= total_items(ndt_q[c]);
					end
				end
				if (wr_sel[c] && reg_idx == DDC_REG_COUNT)
					ndt_q[c] <= reg_wdata[DDC_NDT_W-1:0];
				// Low address bits are kept as written; software aligns them
				if (wr_sel[c] && reg_idx == DDC_REG_SRC)
					src_q[c] <= reg_wdata;
				if (wr_sel[c] && reg_idx == DDC_REG_DST)
					dst_q[c] <= reg_wdata;
				if (item_done[c])
				begin
					if (cfg_q[c][DDC_CTRL_SINC])
						cur_src_q[c] <= cur_src_q[c] + size_step(cfg_q[c][DDC_CTRL_SSIZE_LSB +: 2]);
					if (cfg_q[c][DDC_CTRL_DINC])
						cur_dst_q[c] <= cur_dst_q[c] + size_step(cfg_q[c][DDC_CTRL_DSIZE_LSB +: 2]);
					rem_q[c] <= rem_q[c] - DDC_CNT_ONE;
					if (rem_q[c] == DDC_CNT_ONE && cfg_q[c][DDC_CTRL_CIRC])
					begin
						cur_src_q[c] <= src_q[c];
						cur_dst_q[c] <= dst_q[c];
						rem_q[c]     <= total_items(ndt_q[c]);
					end
					else if (rem_q[c] == DDC_CNT_ONE)
						cfg_q[c][DDC_CTRL_EN] <= 1'b0;
				end
				if (item_err[c])
					cfg_q[c][DDC_CTRL_EN] <= 1'b0;
				// Write one to clear; a same-cycle event keeps its flag
				flags_q[c] <= (flags_q[c] &
					~((wr_sel[c] && reg_idx == DDC_REG_STATUS) ? reg_wdata[DDC_FLAG_W-1:0] : '0)) |
					{item_err[c],
					item_done[c] && rem_q[c] == DDC_CNT_ONE,
					item_done[c] && (rem_q[c] - DDC_CNT_ONE) == (total_items(ndt_q[c]) >> 1)};
			end
		end
	end

	// Peripheral acknowledge and merged interrupt per channel
	always_ff @(posedge clk_sys)
	begin
		for (int c = 0; c < DDC_NUM_CH; c++)
		begin
			if (rst)
			begin
				per_ack[c]  <= 1'b0;
				chan_irq[c] <= 1'b0;
			end
			else
			begin
				per_ack[c]  <= item_done[c];
				chan_irq[c] <= |flags_q[c];
			end
		end
	end

	// Register read port; data stand for one cycle only
	always_ff @(posedge clk_sys)
	begin
		if (rst || !reg_rd || !reg_hit)
			reg_rdata <= 32'h0;
		else
		begin
			unique case (reg_idx)
				DDC_REG_CTRL:   reg_rdata <= 32'(cfg_q[reg_ch]);
				DDC_REG_COUNT:  reg_rdata <= 32'(ndt_q[reg_ch]);
				DDC_REG_SRC:    reg_rdata <= src_q[reg_ch];
				DDC_REG_DST:    reg_rdata <= dst_q[reg_ch];
				DDC_REG_STATUS: reg_rdata <= 32'(flags_q[reg_ch]);
				DDC_REG_REMAIN: reg_rdata <= 32'(rem_q[reg_ch]);
				default:        reg_rdata <= 32'h0;
			endcase
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_read_ok;
		st_q[0] == ENG_READ && mem_ack[0] && !mem_err[0];
	endsequence

	sequence s_start;
		st_q[0] == ENG_IDLE ##1 st_q[0] == ENG_READ;
	endsequence

	for (genvar c = 0; c < DDC_NUM_CH; c++)
	begin : g_chk
		a_err_stops: assert property (item_err[c] |=> !cfg_q[c][DDC_CTRL_EN] && flags_q[c][DDC_FLAG_TE])
			else $error("bus error did not stop channel");
		a_tc_flag: assert property (item_done[c] && rem_q[c] == DDC_CNT_ONE |=>
			flags_q[c][DDC_FLAG_TC] && (rem_q[c] == '0 || cfg_q[c][DDC_CTRL_CIRC]))
			else $error("complete flag missing at end of count");
		a_irq_merge: assert property (item_err[c] |-> ##2 chan_irq[c])
			else $error("error flag did not raise channel interrupt");
		a_circ_reload: assert property (item_done[c] && rem_q[c] == DDC_CNT_ONE &&
			cfg_q[c][DDC_CTRL_CIRC] |=> cfg_q[c][DDC_CTRL_EN] && rem_q[c] == total_items(ndt_q[c]))
			else $error("circular channel did not restart");
	end

	a_half_flag: assert property (item_done[0] && ndt_q[0] == 16'h0004 &&
		rem_q[0] == DDC_CNT_ONE + DDC_CNT_ONE + DDC_CNT_ONE |=> flags_q[0][DDC_FLAG_HT])
		else $error("half flag missing at midpoint");
	a_full_count: assert property (wr_sel[0] && reg_idx == DDC_REG_CTRL &&
		reg_wdata[DDC_CTRL_EN] && !cfg_q[0][DDC_CTRL_EN] && ndt_q[0] == '0 && !item_done[0] |=>
		rem_q[0] == DDC_FULL_COUNT)
		else $error("zero count did not load full count");
	a_tie_lower: assert property (st_q[0] == ENG_IDLE && elig[3] && elig[5] &&
		chan_pri[3] == chan_pri[5] |=> act_q[0] != 4'h5)
		else $error("higher channel won a tie");
	a_prio_wins: assert property (st_q[0] == ENG_IDLE && elig[3] && elig[4] &&
		chan_pri[4] > chan_pri[3] |=> act_q[0] != 4'h3)
		else $error("lower priority channel granted");
	a_read_write: assert property (s_read_ok |=> mem_req[0] && mem_we[0] &&
		mem_addr[0] == cur_dst_q[act_q[0]])
		else $error("write did not follow read");
	a_write_size: assert property (st_q[0] == ENG_WRITE |-> mem_size[0] ==
		cfg_q[act_q[0]][DDC_CTRL_DSIZE_LSB +: 2])
		else $error("write width differs from destination width");
	a_trigger_src: assert property (s_start |-> |($past(trig_ok) & (14'h0001 << act_q[0])))
		else $error("channel started without a trigger");
	a_hold_req: assert property (mem_req[0] && !mem_ack[0] |=> mem_req[0] && $stable(mem_addr[0]))
		else $error("bus request dropped before acknowledge");

endmodule : ddc_top

// ==== sim/ddc_mem_model.sv ====
`timescale 1ns/1ns
module ddc_mem_model
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Bus target side
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	output logic             mem_ack,
	output logic             mem_err,
	output logic      [31:0] mem_rdata,
	// Test control
	input  wire logic [3:0]  wait_cyc,
	input  wire logic        err_arm
);
	logic [3:0] cnt_q = 4'h0;

	initial
	begin
		mem_ack = 1'b0;
		mem_err = 1'b0;
		mem_rdata = 32'h0;
	end

	// Read data toggles outside an answer so a stale sample never matches
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			cnt_q <= 4'h0;
		end
		else if (mem_ack)
		begin
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
		else if (mem_req && cnt_q >= wait_cyc)
		begin
			// Any address answers: memory and peripheral targets look alike
			mem_ack <= 1'b1;
			mem_err <= err_arm;
			mem_rdata <= mem_we ? ~mem_rdata : {mem_addr[15:0] ^ 16'h5a3c, mem_addr[15:0]};
			cnt_q <= 4'h0;
		end
		else
		begin
			cnt_q <= mem_req ? cnt_q + 4'h1 : 4'h0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule : ddc_mem_model

// ==== sim/ddc_top_tb.sv ====
`timescale 1ns/1ns
module ddc_top_tb
	import ddc_pkg::*;
;
	localparam logic [31:0] ctl_word = 32'h0000_0140;
	localparam logic [31:0] ctl_inc  = 32'h0000_0600;
	typedef struct {logic [31:0] a; logic [31:0] d; logic [1:0] z;} ddc_item_type;
	logic                    clk_sys = 1'b0;
	logic                    rst     = 1'b1;
	logic [DDC_ADDR_W-1:0]   reg_addr = '0;
	logic [31:0]             reg_wdata = 32'h0;
	logic                    reg_wr  = 1'b0;
	logic                    reg_rd  = 1'b0;
	wire  [31:0]             reg_rdata;
	logic [DDC_NUM_CH-1:0]   per_req = '0;
	wire  [DDC_NUM_CH-1:0]   per_ack, chan_irq;
	wire  [DDC_NUM_CTRL-1:0] mem_req, mem_we, mem_ack, mem_err;
	wire  [31:0]             mem_addr [DDC_NUM_CTRL];
	wire  [31:0]             mem_wdata [DDC_NUM_CTRL];
	wire  [31:0]             mem_rdata [DDC_NUM_CTRL];
	wire  [1:0]              mem_size [DDC_NUM_CTRL];
	logic [3:0]              wait_cyc [DDC_NUM_CTRL] = '{default: 4'h0};
	logic [DDC_NUM_CTRL-1:0] err_arm = '0;
	int                      fails = 0, tests_run = 0, cycles = 0;
	int                      left_q [DDC_NUM_CH] = '{default: 0};
	ddc_item_type            exp_q [DDC_NUM_CTRL][$];
	logic [31:0]             rd_v, s, d;
	int                      order [5] = '{6, 4, 3, 5, 1};
	int                      pri [5] = '{3, 2, 1, 1, 0};

	ddc_top u_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .per_req(per_req),
		.per_ack(per_ack), .chan_irq(chan_irq), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_err(mem_err), .mem_rdata(mem_rdata));

	for (genvar k = 0; k < DDC_NUM_CTRL; k++)
	begin : g_mem
		ddc_mem_model u_mem (.clk_sys(clk_sys), .rst(rst), .mem_req(mem_req[k]),
			.mem_we(mem_we[k]), .mem_addr(mem_addr[k]), .mem_ack(mem_ack[k]),
			.mem_err(mem_err[k]), .mem_rdata(mem_rdata[k]), .wait_cyc(wait_cyc[k]),
			.err_arm(err_arm[k]));
	end

	always #4 clk_sys = ~clk_sys;

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic reg_write(input int c, input int w, input logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= DDC_ADDR_W'(c * 32 + w * 4);
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input int c, input int w, output logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= DDC_ADDR_W'(c * 32 + w * 4);
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : reg_read

	task automatic cfg(input int c, input logic [31:0] ctl, input int n, input logic [31:0] sa,
		input logic [31:0] da);
		reg_write(c, DDC_REG_COUNT, n);
		reg_write(c, DDC_REG_SRC, sa);
		reg_write(c, DDC_REG_DST, da);
		reg_write(c, DDC_REG_CTRL, ctl);
	endtask : cfg

	function automatic logic [31:0] fit(input logic [31:0] v, input int sz);
		return sz == 0 ? v & 32'hff : (sz == 1 ? v & 32'hffff : v);
	endfunction : fit

	// Expected writes of k items over a buffer of n, wrapping as a circular channel would
	task automatic expect_items(input int c, input int n, input int k, input logic [31:0] sa,
		input logic [31:0] da, input int ss, input int ds);
		ddc_item_type it;
		logic [31:0]  a;
		for (int i = 0; i < k; i++)
		begin
			a = sa + ((i % n) << ss);
			it.a = da + ((i % n) << ds);
			it.z = 2'(ds);
			it.d = fit(fit({a[15:0] ^ 16'h5a3c, a[15:0]}, ss), ds);
			exp_q[c / DDC_CH_PER_CTRL].push_back(it);
		end
	endtask : expect_items

	task automatic wait_idle;
		for (int i = 0; i < 3000 && exp_q[0].size() + exp_q[1].size() != 0; i++)
			@(posedge clk_sys);
		repeat (8) @(posedge clk_sys);
		check(exp_q[0].size() + exp_q[1].size(), 0);
	endtask : wait_idle

	task automatic status_is(input int c, input logic [31:0] flags, input logic en);
		reg_read(c, DDC_REG_STATUS, rd_v);
		check(rd_v, flags);
		reg_read(c, DDC_REG_CTRL, rd_v);
		check(rd_v[0], en);
		check(chan_irq[c], 1'b1);
		reg_write(c, DDC_REG_STATUS, 32'h7);
		repeat (3) @(posedge clk_sys);
		check(chan_irq[c], 1'b0);
	endtask : status_is

	// Peripheral drops its request at the edge that shows the acknowledge of its last item
	always @(posedge clk_sys)
		for (int c = 0; c < DDC_NUM_CH; c++)
		begin
			if (per_ack[c])
				left_q[c]--;
			per_req[c] <= left_q[c] > 0;
		end

	always @(posedge clk_sys)
		for (int k = 0; k < DDC_NUM_CTRL; k++)
			if (!rst && mem_req[k] && mem_we[k] && mem_ack[k])
			begin
				if (exp_q[k].size() == 0)
					check(32'h1, 32'h0);
				else
				begin
					check(mem_addr[k], exp_q[k][0].a);
					check(mem_wdata[k], exp_q[k][0].d);
					check(mem_size[k], exp_q[k][0].z);
					void'(exp_q[k].pop_front());
				end
			end

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			fails++;
			final_report();
		end
	end

	initial
	begin
		void'($urandom(79789));
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		reg_read(0, DDC_REG_CTRL, rd_v);
		check(rd_v, 32'h0);
		reg_read(0, 6, rd_v);
		check(rd_v, 32'h0);
		s = $urandom;
		reg_write(13, DDC_REG_SRC, s);
		reg_read(13, DDC_REG_SRC, rd_v);
		check(rd_v, s);
		reg_write(14, DDC_REG_SRC, s);
		reg_read(14, DDC_REG_SRC, rd_v);
		check(rd_v, 32'h0);
		reg_write(13, DDC_REG_REMAIN, s);
		reg_read(13, DDC_REG_REMAIN, rd_v);
		check(rd_v, 32'h0);
		cfg(0, 32'h1, 0, 32'h0, 32'h0);
		reg_read(0, DDC_REG_REMAIN, rd_v);
		check(rd_v, 32'h10000);
		reg_write(0, DDC_REG_CTRL, 32'h0);
		// Every width pairing, software triggered, spread over both controllers
		for (int ss = 0; ss < 3; ss++)
			for (int ds = 0; ds < 3; ds++)
			begin
				s = $urandom & 32'hfff0;
				d = s ^ 32'h8000;
				wait_cyc[(ss * 3 + ds) / DDC_CH_PER_CTRL] <= 4'($urandom_range(0, 3));
				expect_items(ss * 3 + ds, 4, 4, s, d, ss, ds);
				cfg(ss * 3 + ds, 32'h5 | ctl_inc | (ss << 5) | (ds << 7), 4, s, d);
				wait_idle();
				reg_read(ss * 3 + ds, DDC_REG_REMAIN, rd_v);
				check(rd_v, 32'h0);
				status_is(ss * 3 + ds, 32'h3, 1'b0);
			end
		// Five channels raise hardware requests together
		wait_cyc[0] <= 4'h0;
		for (int i = 0; i < 5; i++)
		begin
			cfg(order[i], 32'h1 | ctl_word | (pri[i] << 3), 1, order[i] << 8, 32'h4000);
			expect_items(order[i], 1, 1, order[i] << 8, 32'h4000, 2, 2);
		end
		for (int i = 0; i < 5; i++)
			left_q[order[i]] = 1;
		wait_idle();
		check(per_req, 32'h0);
		// Failed read stops the channel with no write
		err_arm[1] <= 1'b1;
		cfg(10, 32'h5 | ctl_word | ctl_inc, 3, 32'h2000, 32'h6000);
		repeat (30) @(posedge clk_sys);
		err_arm[1] <= 1'b0;
		reg_read(10, DDC_REG_REMAIN, rd_v);
		check(rd_v, 32'h3);
		status_is(10, 32'h4, 1'b0);
		// Circular buffer of two items, five requests, slow target
		wait_cyc[1] <= 4'h3;
		expect_items(11, 2, 5, 32'h3000, 32'h7000, 2, 2);
		cfg(11, 32'h3 | ctl_word | ctl_inc, 2, 32'h3000, 32'h7000);
		left_q[11] = 5;
		wait_idle();
		reg_read(11, DDC_REG_REMAIN, rd_v);
		check(rd_v, 32'h1);
		status_is(11, 32'h3, 1'b1);
		final_report();
	end
endmodule : ddc_top_tb
